// [core/srs_pkg.sv]
// Constants, states and helpers shared by the SPI register slave and its master.
// Assumes both ends run from one 10 MHz mclk_i.
package srs_pkg;
   localparam int unsigned SRS_AW        = 6;
   localparam int unsigned SRS_DW        = 16;
   localparam int unsigned SRS_PHY_W     = 5;
   localparam logic [5:0]  SRS_MATCH_IDX = 6'h3F;
   localparam int unsigned SRS_MATCH_EN  = 15;
   localparam logic [15:0] SRS_MEM_RST   = 16'h0000;
   localparam logic [3:0]  SRS_CTRL_LAST = 4'h7;
   localparam logic [3:0]  SRS_DATA_LAST = 4'hF;
   localparam int unsigned SRS_MCLK_NS   = 100;
   localparam int unsigned SRS_SCLK_NS   = 800;
   localparam int unsigned SRS_HALF_CYC  = SRS_SCLK_NS / (2 * SRS_MCLK_NS);
   localparam int unsigned SRS_SYNC_LAT  = 4;
   localparam logic [2:0]  SRS_R_CMD     = 3'h0;
   localparam logic [2:0]  SRS_R_CFG     = 3'h1;
   localparam logic [2:0]  SRS_R_TXD     = 3'h2;
   localparam logic [2:0]  SRS_R_RXD     = 3'h3;
   localparam logic [2:0]  SRS_R_STAT    = 3'h4;
   localparam logic [2:0]  SRS_CFG_RST   = 3'h0;

   typedef enum logic [3:0] {
      SRS_D_IDLE = 4'h1,
      SRS_D_CTRL = 4'h2,
      SRS_D_WR   = 4'h4,
      SRS_D_RD   = 4'h8
   } srs_dst_t;

   typedef enum logic [5:0] {
      SRS_M_IDLE  = 6'h01,
      SRS_M_SETUP = 6'h02,
      SRS_M_LOAD  = 6'h04,
      SRS_M_RUN   = 6'h08,
      SRS_M_WAITC = 6'h10,
      SRS_M_END   = 6'h20
   } srs_mst_t;

   function automatic logic [5:0] srs_rev6(input logic [5:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < 6; i++)
         r[i] = v[5-i];
      return r;
   endfunction

   function automatic logic [15:0] srs_rev16(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++)
         r[i] = v[15-i];
      return r;
   endfunction
endpackage

// [core/srs_if.sv]
// Four-wire link between the register slave and its master.
// Assumes a pull-up on the returned data wire while nobody drives it.
`timescale 1ns/1ps
`default_nettype none
interface srs_if;
   logic sclk_pin;
   logic select_n_pin;
   logic serial_in_pin;
   logic serial_in_oe;
   logic serial_out_pin;
   logic serial_out_oe;
   logic serial_out_line;

   assign serial_out_line = serial_out_oe ? serial_out_pin : 1'b1;

   modport dev (input sclk_pin, select_n_pin, serial_in_pin, output serial_out_pin, serial_out_oe);
   modport mst (output sclk_pin, select_n_pin, serial_in_pin, serial_in_oe, input serial_out_line);
endinterface
`default_nettype wire

// [core/srs_dev.sv]
// Device end: SPI slave giving access to 64 registers of 16 bits.
// Assumes link pins are asynchronous; cpol/cpha/lsb/disable come from mclk logic.
// Functional notes
// - Slave only; master starts and clocks
// - Output floats unless shifting read data
// - Enabled after reset; disable input blocks it
// - Six-bit address, 16-bit registers
// - Clock idle level follows polarity
// - Phase selects sampling and output edges
// - Clock may stand still while deselected
// - Deselect floats output at once, aborts
// - Select falling edge starts a transaction
// - Control word: direction, address, burst
// - LSB-first option reverses address and data
// - Direction 1 reads; burst 1 bursts
// - Data words MSB first by default
// - Single write commits after last bit
// - Single read returns addressed word
// - Burst write stores, increments, continues
// - Burst address wraps 1Fh to 00h
// - Burst read prefetches next word
// - Master avoids ending before latched status
// - Aborted partial write is not stored
// - Shared wire: master floats while device drives
// - Match register gates which device answers
// - Device address strapped during reset
`timescale 1ns/1ps
`default_nettype none
module srs_dev
(
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_i,
   srs_if.dev               lnk,
   input  wire logic        cpol_i,
   input  wire logic        cpha_i,
   input  wire logic        lsb_first_select_i,
   input  wire logic        serial_port_disable_i,
   input  wire logic [3:0]  receive_data_hi_i,
   input  wire logic        receive_error_pin_i,
   output logic             wr_pulse_o,
   output logic [5:0]       wr_addr_o,
   output logic [15:0]      wr_data_o,
   output logic             rd_pulse_o,
   output logic [5:0]       rd_addr_o,
   output logic [4:0]       phy_addr_o
);
   logic [2:0]        sck_s;
   logic [2:0]        sel_s;
   logic [2:0]        sdi_s;
   logic              sck_f;
   logic              sel_f;
   logic              sdi_f;
   logic              sck_fq;
   logic              sel_fq;
   srs_pkg::srs_dst_t st_q;
   logic [3:0]        cnt_q;
   logic [15:0]       rx_q;
   logic [15:0]       rx_n;
   logic [15:0]       tx_q;
   logic [5:0]        addr_q;
   logic [5:0]        addr_inc;
   logic [5:0]        ca;
   logic              burst_q;
   logic              mute_q;
   logic              drive_q;
   logic              sdo_q;
   logic [4:0]        phy_q;
   logic [15:0]       mem [64];
   logic              rise;
   logic              fall;
   logic              lead;
   logic              trail;
   logic              samp;
   logic              shft;
   logic              sel_start;
   logic              respond;
   logic              last;

   // Pins are unrelated to mclk; a level counts once stages 2 and 3 agree
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         sck_s  <= 3'h0;
         sel_s  <= 3'h7;
         sdi_s  <= 3'h0;
         sck_f  <= 1'b0;
         sel_f  <= 1'b1;
         sdi_f  <= 1'b0;
         sck_fq <= 1'b0;
         sel_fq <= 1'b1;
      end
      else if (ce_i)
      begin
         sck_s  <= {sck_s[1:0], lnk.sclk_pin};
         sel_s  <= {sel_s[1:0], lnk.select_n_pin};
         sdi_s  <= {sdi_s[1:0], lnk.serial_in_pin};
         if (sck_s[1] == sck_s[2])
            sck_f <= sck_s[2];
         if (sel_s[1] == sel_s[2])
            sel_f <= sel_s[2];
         if (sdi_s[1] == sdi_s[2])
            sdi_f <= sdi_s[2];
         sck_fq <= sck_f;
         sel_fq <= sel_f;
      end
   end

   assign rise      = sck_f & ~sck_fq;
   assign fall      = ~sck_f & sck_fq;
   assign lead      = cpol_i ? fall : rise;
   assign trail     = cpol_i ? rise : fall;
   assign samp      = cpha_i ? trail : lead;
   assign shft      = cpha_i ? lead : trail;
   assign sel_start = sel_fq & ~sel_f;
   assign last      = (st_q == srs_pkg::SRS_D_CTRL) ? (cnt_q == srs_pkg::SRS_CTRL_LAST)
                                                    : (cnt_q == srs_pkg::SRS_DATA_LAST);
   assign ca        = lsb_first_select_i ? srs_pkg::srs_rev6(rx_q[5:0]) : rx_q[5:0];
   assign addr_inc  = {addr_q[5], 5'(addr_q[4:0] + 5'h01)};
   // LSB-first data shifts in from the top so bit 0 ends up first-received
   assign rx_n      = (lsb_first_select_i && st_q != srs_pkg::SRS_D_CTRL) ? {sdi_f, rx_q[15:1]}
                                                                          : {rx_q[14:0], sdi_f};
   assign respond   = !mem[srs_pkg::SRS_MATCH_IDX][srs_pkg::SRS_MATCH_EN]
                      || (mem[srs_pkg::SRS_MATCH_IDX][4:0] == phy_q);

   // Sequencing; the clock is only looked at while selected
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         st_q <= srs_pkg::SRS_D_IDLE;
      else if (ce_i)
      begin
         if (sel_f)
            st_q <= srs_pkg::SRS_D_IDLE;
         else
         begin
            case (st_q)
               srs_pkg::SRS_D_IDLE:
                  if (sel_start && !serial_port_disable_i)
                     st_q <= srs_pkg::SRS_D_CTRL;
               srs_pkg::SRS_D_CTRL:
                  if (samp && last)
                     st_q <= rx_q[6] ? srs_pkg::SRS_D_RD : srs_pkg::SRS_D_WR;
               srs_pkg::SRS_D_WR,
               srs_pkg::SRS_D_RD:
                  if (samp && last && !burst_q)
                     st_q <= srs_pkg::SRS_D_CTRL;
               default:
                  st_q <= srs_pkg::SRS_D_IDLE;
            endcase
         end
      end
   end

   // Shift paths, address counter and register access pulses
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         cnt_q      <= 4'h0;
         rx_q       <= 16'h0000;
         tx_q       <= 16'h0000;
         addr_q     <= 6'h00;
         burst_q    <= 1'b0;
         mute_q     <= 1'b0;
         drive_q    <= 1'b0;
         sdo_q      <= 1'b0;
         wr_pulse_o <= 1'b0;
         wr_addr_o  <= 6'h00;
         wr_data_o  <= 16'h0000;
         rd_pulse_o <= 1'b0;
         rd_addr_o  <= 6'h00;
      end
      else if (ce_i)
      begin
         wr_pulse_o <= 1'b0;
         rd_pulse_o <= 1'b0;
         if (sel_f || st_q == srs_pkg::SRS_D_IDLE)
         begin
            cnt_q   <= 4'h0;
            drive_q <= 1'b0;
         end
         else if (samp)
         begin
            cnt_q <= last ? 4'h0 : 4'(cnt_q + 4'h1);
            rx_q  <= rx_n;
            if (last && st_q == srs_pkg::SRS_D_CTRL)
            begin
               addr_q  <= ca;
               burst_q <= sdi_f;
               // Match register stays writable so a muted device can be re-addressed
               mute_q  <= !respond && (ca != srs_pkg::SRS_MATCH_IDX);
               if (rx_q[6])
               begin
                  tx_q       <= mem[ca];
                  rd_pulse_o <= respond;
                  rd_addr_o  <= ca;
               end
            end
            else if (last && st_q == srs_pkg::SRS_D_WR)
            begin
               wr_pulse_o <= !mute_q;
               wr_addr_o  <= addr_q;
               wr_data_o  <= rx_n;
               if (burst_q)
                  addr_q <= addr_inc;
            end
            else if (last && st_q == srs_pkg::SRS_D_RD)
            begin
               if (burst_q)
               begin
                  // Prefetch may clear latched status in the next register
                  addr_q     <= addr_inc;
                  tx_q       <= mem[addr_inc];
                  rd_pulse_o <= !mute_q;
                  rd_addr_o  <= addr_inc;
               end
               else
                  drive_q <= 1'b0;
            end
         end
         else if (shft && st_q == srs_pkg::SRS_D_RD)
         begin
            sdo_q   <= lsb_first_select_i ? tx_q[0] : tx_q[15];
            tx_q    <= lsb_first_select_i ? {1'b0, tx_q[15:1]} : {tx_q[14:0], 1'b0};
            drive_q <= !mute_q;
         end
      end
   end

   // Register space; a write lands one cycle after its pulse is raised
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < 64; i++)
            mem[i] <= srs_pkg::SRS_MEM_RST;
      end
      else if (ce_i && wr_pulse_o)
         mem[wr_addr_o] <= wr_data_o;
   end

   // Address straps are caught on every clocked edge while reset is held
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         phy_q <= {receive_data_hi_i, receive_error_pin_i};
   end

   assign phy_addr_o         = phy_q;
   assign lnk.serial_out_pin = sdo_q;
   // Raw select gates the enable so the float does not wait for the synchroniser
   assign lnk.serial_out_oe  = drive_q & ~lnk.select_n_pin;
endmodule // srs_dev
`default_nettype wire

// [core/srs_mst.sv]
// Master end: drives the SPI register slave from a small register port.
// Assumes software waits on status flags; no data buffering beyond one word each way.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module srs_mst #(
   parameter int unsigned HALF = srs_pkg::SRS_HALF_CYC
)
(
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_i,
   srs_if.mst               lnk,
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [15:0]      reg_rdata_o
);
   localparam int unsigned DLY = HALF + srs_pkg::SRS_SYNC_LAT;

   logic [2:0]        mi_s;
   logic              mi_f;
   srs_pkg::srs_mst_t st_q;
   logic [7:0]        div_q;
   logic              tick;
   logic [2:0]        cfg_q;
   logic [12:0]       cmd_q;
   logic [15:0]       txd_q;
   logic [15:0]       rxd_q;
   logic [15:0]       sh_q;
   logic [15:0]       rx_sh;
   logic              tx_full_q;
   logic              rx_valid_q;
   logic              sclk_q;
   logic              sel_n_q;
   logic              mosi_q;
   logic              oe_q;
   logic              half_q;
   logic              ctl_q;
   logic [3:0]        bit_q;
   logic [4:0]        capn_q;
   logic [4:0]        left_q;
   logic [DLY-1:0]    cap_sr;
   logic [3:0]        lastb;
   logic [7:0]        ctrl8;
   logic [15:0]       load_w;
   logic              is_rd;
   logic              edge_t;
   logic              samp_now;
   logic              load_fire;
   logic              word_done;

   assign is_rd     = cmd_q[6];
   assign lastb     = ctl_q ? srs_pkg::SRS_DATA_LAST : srs_pkg::SRS_CTRL_LAST;
   assign ctrl8     = {cmd_q[6], cfg_q[2] ? srs_pkg::srs_rev6(cmd_q[5:0]) : cmd_q[5:0], cmd_q[7]};
   assign load_w    = !ctl_q ? {ctrl8, 8'h00} : (cfg_q[2] ? srs_pkg::srs_rev16(txd_q) : txd_q);
   assign load_fire = (st_q == srs_pkg::SRS_M_LOAD) && (!ctl_q || (is_rd ? !rx_valid_q : tx_full_q));
   assign tick      = (div_q == 8'(HALF - 1));
   assign edge_t    = (st_q == srs_pkg::SRS_M_RUN) && tick;
   assign samp_now  = edge_t && (half_q ? cfg_q[1] : !cfg_q[1]);
   assign word_done = (st_q == srs_pkg::SRS_M_WAITC) && (capn_q == 5'({1'b0, lastb} + 5'h01));

   // Returned data comes from another device's pin
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         mi_s <= 3'h7;
         mi_f <= 1'b1;
      end
      else if (ce_i)
      begin
         mi_s <= {mi_s[1:0], lnk.serial_out_line};
         if (mi_s[1] == mi_s[2])
            mi_f <= mi_s[2];
      end
   end

   // Half-period divider, restarted per word so the first edge keeps setup
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         div_q <= 8'h00;
      else if (ce_i)
         div_q <= (load_fire || tick) ? 8'h00 : 8'(div_q + 8'h01);
   end

   // Sampling is delayed to cover both ends' synchronisers
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         cap_sr <= '0;
         rx_sh  <= 16'h0000;
         capn_q <= 5'h00;
      end
      else if (ce_i)
      begin
         cap_sr <= {cap_sr[DLY-2:0], samp_now};
         if (load_fire)
            capn_q <= 5'h00;
         else if (cap_sr[DLY-1])
         begin
            rx_sh  <= {rx_sh[14:0], mi_f};
            capn_q <= 5'(capn_q + 5'h01);
         end
      end
   end

   // Software registers; hardware set wins over software clear
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         cfg_q       <= srs_pkg::SRS_CFG_RST;
         cmd_q       <= 13'h0000;
         txd_q       <= 16'h0000;
         rxd_q       <= 16'h0000;
         tx_full_q   <= 1'b0;
         rx_valid_q  <= 1'b0;
         reg_rdata_o <= 16'h0000;
      end
      else if (ce_i)
      begin
         if (reg_wr_i && reg_addr_i == srs_pkg::SRS_R_CFG && st_q == srs_pkg::SRS_M_IDLE)
            cfg_q <= reg_wdata_i[2:0];
         if (reg_wr_i && reg_addr_i == srs_pkg::SRS_R_CMD && st_q == srs_pkg::SRS_M_IDLE)
            cmd_q <= reg_wdata_i[12:0];
         if (reg_wr_i && reg_addr_i == srs_pkg::SRS_R_TXD)
            txd_q <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == srs_pkg::SRS_R_TXD)
            tx_full_q <= 1'b1;
         else if (load_fire && ctl_q)
            tx_full_q <= 1'b0;
         if (word_done && ctl_q && is_rd)
         begin
            rxd_q      <= cfg_q[2] ? srs_pkg::srs_rev16(rx_sh) : rx_sh;
            rx_valid_q <= 1'b1;
         end
         else if (reg_rd_i && reg_addr_i == srs_pkg::SRS_R_RXD)
            rx_valid_q <= 1'b0;
         reg_rdata_o <= 16'h0000;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               srs_pkg::SRS_R_CMD:  reg_rdata_o <= {3'h0, cmd_q};
               srs_pkg::SRS_R_CFG:  reg_rdata_o <= {13'h0000, cfg_q};
               srs_pkg::SRS_R_TXD:  reg_rdata_o <= txd_q;
               srs_pkg::SRS_R_RXD:  reg_rdata_o <= rxd_q;
               srs_pkg::SRS_R_STAT: reg_rdata_o <= {13'h0000, rx_valid_q, tx_full_q, st_q != srs_pkg::SRS_M_IDLE};
               default:             reg_rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   // Link sequencing; clock is held still between words when software lags
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         st_q    <= srs_pkg::SRS_M_IDLE;
         sclk_q  <= 1'b0;
         sel_n_q <= 1'b1;
         mosi_q  <= 1'b0;
         oe_q    <= 1'b0;
         half_q  <= 1'b0;
         ctl_q   <= 1'b0;
         bit_q   <= 4'h0;
         left_q  <= 5'h00;
         sh_q    <= 16'h0000;
      end
      else if (ce_i)
      begin
         case (st_q)
            srs_pkg::SRS_M_IDLE:
            begin
               sclk_q <= cfg_q[0];
               if (reg_wr_i && reg_addr_i == srs_pkg::SRS_R_CMD)
               begin
                  sel_n_q <= 1'b0;
                  ctl_q   <= 1'b0;
                  left_q  <= reg_wdata_i[7] ? reg_wdata_i[12:8] : 5'h00;
                  st_q    <= srs_pkg::SRS_M_SETUP;
               end
            end
            srs_pkg::SRS_M_SETUP:
               if (tick)
                  st_q <= srs_pkg::SRS_M_LOAD;
            srs_pkg::SRS_M_LOAD:
               if (load_fire)
               begin
                  sh_q   <= cfg_q[1] ? load_w : {load_w[14:0], 1'b0};
                  mosi_q <= cfg_q[1] ? mosi_q : load_w[15];
                  oe_q   <= !(ctl_q && is_rd);
                  half_q <= 1'b0;
                  bit_q  <= 4'h0;
                  st_q   <= srs_pkg::SRS_M_RUN;
               end
            srs_pkg::SRS_M_RUN:
               if (tick)
               begin
                  half_q <= !half_q;
                  sclk_q <= half_q ? cfg_q[0] : !cfg_q[0];
                  if (half_q ? (!cfg_q[1] && bit_q != lastb) : cfg_q[1])
                  begin
                     mosi_q <= sh_q[15];
                     sh_q   <= {sh_q[14:0], 1'b0};
                  end
                  if (half_q)
                  begin
                     bit_q <= 4'(bit_q + 4'h1);
                     if (bit_q == lastb)
                        st_q <= srs_pkg::SRS_M_WAITC;
                     // Free the wire before the device puts out its first read bit
                     if (bit_q == lastb && !ctl_q && is_rd)
                        oe_q <= 1'b0;
                  end
               end
            srs_pkg::SRS_M_WAITC:
               if (word_done)
               begin
                  ctl_q <= 1'b1;
                  if (ctl_q && left_q == 5'h00)
                     st_q <= srs_pkg::SRS_M_END;
                  else
                  begin
                     if (ctl_q)
                        left_q <= 5'(left_q - 5'h01);
                     st_q <= srs_pkg::SRS_M_LOAD;
                  end
               end
            srs_pkg::SRS_M_END:
            begin
               oe_q <= 1'b0;
               if (tick && !sel_n_q)
                  sel_n_q <= 1'b1;
               else if (tick)
                  st_q <= srs_pkg::SRS_M_IDLE;
            end
            default:
               st_q <= srs_pkg::SRS_M_IDLE;
         endcase
      end
   end

   assign lnk.sclk_pin      = sclk_q;
   assign lnk.select_n_pin  = sel_n_q;
   assign lnk.serial_in_pin = mosi_q;
   assign lnk.serial_in_oe  = oe_q;
endmodule // srs_mst
`default_nettype wire

// [test/srs_chk.sv]
// Link checker for the register slave and its master.
// Assumes one mclk_i domain; sits beside the interface instance.
`timescale 1ns/1ps
`default_nettype none
module srs_chk
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic sclk_pin,
   input wire logic select_n_pin,
   input wire logic serial_in_oe,
   input wire logic serial_out_oe
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   out_float_a: assert property (select_n_pin |-> !serial_out_oe)
      else $error("data out driven while deselected");
   no_contend_a: assert property (!(serial_in_oe && serial_out_oe))
      else $error("both ends drive the data wire");
   out_cause_a: assert property ($rose(serial_out_oe) |-> !select_n_pin && !serial_in_oe)
      else $error("data out driven outside read phase");
   ctrl_start_a: assert property ($fell(select_n_pin) |-> ##[1:8] serial_in_oe)
      else $error("no control word after select");
   ctrl_quiet_a: assert property ($fell(select_n_pin) |-> !serial_out_oe [*8])
      else $error("device drives during control word");
   sclk_idle_a: assert property ($rose(select_n_pin) |-> $stable(sclk_pin) [*3])
      else $error("serial clock moves after deselect");
   sclk_half_a: assert property ($changed(sclk_pin) |=> $stable(sclk_pin) [*3])
      else $error("serial clock half period too short");
   mst_release_a: assert property ($rose(select_n_pin) |-> !serial_in_oe)
      else $error("master drives data after deselect");
   cover property ($fell(select_n_pin));
   cover property ($rose(serial_out_oe));
   cover property (!select_n_pin && $changed(sclk_pin));
endmodule // srs_chk
`default_nettype wire

// [test/spi_register_slave_tb.sv]
// Bench joining the register slave and its master over one link.
// Assumes master map: 0 command, 1 config, 2 tx data, 3 rx data, 4 status.
`timescale 1ns/1ps
`default_nettype none
module spi_register_slave_tb;
   logic        mclk_i, nrst_i, ce, cpol, cpha, lsb, dis, receive_error_pin, we, re, wp, rp;
   logic [3:0]  rxd_hi;
   logic [2:0]  ra;
   logic [4:0]  phy;
   logic [5:0]  wa, la, rda, lr;
   logic [15:0] wd, rdata, wdat, ld, d;
   logic [23:0] sh;
   int          n_errors, total_checks, nwr, cyc, n0;
   srs_if lnk ();
   srs_dev i_srs_dev (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce), .lnk(lnk.dev), .cpol_i(cpol),
      .cpha_i(cpha), .lsb_first_select_i(lsb), .serial_port_disable_i(dis), .receive_data_hi_i(rxd_hi),
      .receive_error_pin_i(receive_error_pin), .wr_pulse_o(wp), .wr_addr_o(wa), .wr_data_o(wdat), .rd_pulse_o(rp),
      .rd_addr_o(rda), .phy_addr_o(phy));
   srs_mst i_srs_mst (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce), .lnk(lnk.mst), .reg_addr_i(ra),
      .reg_wdata_i(wd), .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdata));
   srs_chk i_srs_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_pin(lnk.sclk_pin),
      .select_n_pin(lnk.select_n_pin), .serial_in_oe(lnk.serial_in_oe), .serial_out_oe(lnk.serial_out_oe));
   always #50 mclk_i = ~mclk_i;
   // Wire bits as sampled on rising serial clock; meaningful in modes 0 and 3, which both sample on that edge
   always @(posedge lnk.sclk_pin)
      if (!lnk.select_n_pin)
         sh <= {sh[22:0], lnk.serial_in_pin};
   always @(posedge mclk_i)
      if (wp === 1'h1)
      begin
         nwr <= nwr + 1;
         la <= wa;
         ld <= wdat;
      end
   always @(posedge mclk_i)
      if (rp === 1'h1)
         lr <= rda;
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         n_errors = n_errors + 1;
         results();
      end
   end
   task automatic results();
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge mclk_i);
      ra <= a;
      wd <= v;
      we <= 1'h1;
      @(posedge mclk_i);
      we <= 1'h0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] v);
      @(posedge mclk_i);
      ra <= a;
      re <= 1'h1;
      @(posedge mclk_i);
      re <= 1'h0;
      #1;
      v = rdata;
   endtask
   task automatic poll(input int b, input logic v);
      logic [15:0] s;
      for (int i = 0; i < 3000; i++)
      begin
         rd(3'h4, s);
         if (s[b] === v)
            return;
      end
      chk("status wait", 24'h1, 24'h0);
   endtask
   task automatic mode(input logic p, input logic h, input logic l);
      @(posedge mclk_i);
      cpol <= p;
      cpha <= h;
      lsb <= l;
      wr(3'h1, {13'h0, l, h, p});
   endtask
   // Burst of n words from address a; n of 1 is a single access
   task automatic xw(input logic [5:0] a, input int n, input logic [15:0] v);
      wr(3'h2, v);
      wr(3'h0, {3'h0, 5'(n - 1), (n > 1), 1'h0, a});
      for (int i = 1; i < n; i++)
      begin
         poll(1, 1'h0);
         wr(3'h2, v + 16'(i));
      end
      poll(0, 1'h0);
   endtask
   task automatic xr(input logic [5:0] a, input int n, input logic [15:0] v);
      logic [15:0] g;
      wr(3'h0, {3'h0, 5'(n - 1), (n > 1), 1'h1, a});
      for (int i = 0; i < n; i++)
      begin
         poll(2, 1'h1);
         rd(3'h3, g);
         chk("read word", 24'(v + 16'(i)), 24'(g));
      end
      poll(0, 1'h0);
   endtask
   initial
   begin
      {mclk_i, nrst_i, cpol, cpha, lsb, dis, we, re, ra, wd, sh} = '0;
      {ce, receive_error_pin, rxd_hi} = 6'h3A;
      {n_errors, total_checks, nwr, cyc} = '0;
      repeat (3) @(posedge mclk_i);
      nrst_i <= 1'h1;
      repeat (5) @(posedge mclk_i);
      chk("strap address", 24'h15, 24'(phy));
      xr(6'h15, 1, 16'h0000);
      chk("fetch address", 24'h15, 24'(lr));
      for (int m = 0; m < 4; m++)
      begin
         mode(m[0], m[1], m[0]);
         xw(6'(m * 20 + 1), 1, 16'hA5C3 ^ 16'(m));
         chk("commit", {2'h0, 6'(m * 20 + 1), 16'hA5C3 ^ 16'(m)}, {2'h0, la, ld});
         if (m == 0)
            chk("wire bits", {1'h0, 6'h01, 1'h0, 16'hA5C3}, sh);
         xr(6'(m * 20 + 1), 1, 16'hA5C3 ^ 16'(m));
      end
      mode(1'h0, 1'h0, 1'h0);
      xw(6'h1E, 3, 16'h1230);
      xr(6'h1E, 3, 16'h1230);
      chk("prefetch address", 24'h01, 24'(lr));
      xr(6'h00, 1, 16'h1232);
      @(posedge mclk_i) dis <= 1'h1;
      n0 = nwr;
      xw(6'h05, 1, 16'hBEEF);
      chk("writes while off", 24'(n0), 24'(nwr));
      xr(6'h05, 1, 16'hFFFF);
      @(posedge mclk_i) dis <= 1'h0;
      xr(6'h05, 1, 16'h0000);
      xw(6'h3F, 1, 16'h8015);
      xw(6'h07, 1, 16'h0707);
      xr(6'h07, 1, 16'h0707);
      xw(6'h3F, 1, 16'h8014);
      n0 = nwr;
      xw(6'h07, 1, 16'h7777);
      chk("writes muted", 24'(n0), 24'(nwr));
      xr(6'h07, 1, 16'hFFFF);
      xw(6'h3F, 1, 16'h0000);
      xr(6'h07, 1, 16'h0707);
      results();
   end
endmodule // spi_register_slave_tb
`default_nettype wire
